// file: verilog/dsfe_top.sv
// sample-rate front end: converter nibble link, receive and transmit filters, dpll
//
// Overview of operation
// - sample words are 16 bits over 4 lines
// - one word takes exactly four cycles
// - receive: word interface, selector, decimator, equalizer
// - selector can loop transmit samples back
// - decimator reduces four words to one
// - equalizer is FIR with programmable taps
// - decimator and equalizer each bypassable
// - transmit: sidelobe, clip, delay equalize, interpolate
// - sidelobe and delay equalizer are IIR
// - clipping bounds transmit sample magnitude
// - interpolator makes four words per sample
// - dpll takes pilot phase error metric
// - low pass then integrator gives offset
// - small phase error goes to rotor
// - large phase error slips or inserts samples
// - tracking keeps mismatch below 2ppm
// - power-off output drives converter reset
// - single serial line carries control data
`timescale 1ns/1ns
module dsfe_top #(
   parameter int TEQ_TAPS = 4
) (
   input logic i_clk,
   input logic i_rst_b,
   input logic i_psel,
   input logic i_penable,
   input logic i_pwrite,
   input logic [7:0] i_paddr,
   input logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input logic [dsfe_pkg::NIB_W-1:0] i_conv_rx_nibble,
   input logic i_word_start_mark,
   output logic [dsfe_pkg::NIB_W-1:0] o_conv_tx_nibble,
   output logic [dsfe_pkg::NIB_W-1:0] o_conv_echo_nibble,
   output logic o_conv_power_off,
   output logic o_conv_ctrl_serial_out,
   input logic signed [dsfe_pkg::SMP_W-1:0] i_tx_sample,
   output logic o_tx_ready,
   input logic [dsfe_pkg::SMP_W-1:0] i_echo_word,
   output logic signed [dsfe_pkg::SMP_W-1:0] o_rx_sample,
   output logic o_rx_valid,
   input logic signed [dsfe_pkg::SMP_W-1:0] i_pilot_err,
   input logic i_pilot_valid,
   output logic signed [dsfe_pkg::SMP_W-1:0] o_rotor_phase
);
   import dsfe_pkg::*;

   // ==========================================================
   // helpers
   function automatic logic signed [SMP_W-1:0] sat16(input logic signed [AW-1:0] v);
      if (v > SAT_HI) begin
         sat16 = SAT_HI[SMP_W-1:0];
      end else if (v < SAT_LO) begin
         sat16 = SAT_LO[SMP_W-1:0];
      end else begin
         sat16 = v[SMP_W-1:0];
      end
   endfunction

   function automatic logic signed [AW-1:0] q15mul(input logic signed [SMP_W-1:0] a,
                                                   input logic signed [SMP_W-1:0] b);
      q15mul = (AW'(a) * AW'(b)) >>> Q_SH;
   endfunction

   function automatic logic teq_hit(input logic [7:0] a);
      teq_hit = (a >= OFS_TEQ_BASE) && (32'(a[7:2] - OFS_TEQ_BASE[7:2]) < TEQ_TAPS);
   endfunction

   // ==========================================================
   // registers
   dsfe_ctrl_s ctrl;
   logic [14:0] clip_lvl;
   logic signed [SMP_W-1:0] sl_coef;
   logic signed [SMP_W-1:0] de_coef;
   logic signed [31:0] slip_thr;
   logic signed [SMP_W-1:0] teq_coef [TEQ_TAPS];
   logic wr_en;
   logic hit;
   logic [31:0] rd_val;
   logic [5:0] teq_idx;

   // link side
   logic [2:0] mark_s;
   logic [NIB_W-1:0] rx_s1, rx_s2, rx_s3, rx_d4;
   logic mark_f, mark_f_q, word_start, aligned;
   logic [1:0] nib_idx, nib_cur;
   logic [11:0] rx_acc;
   logic word_done;
   logic [SMP_W-1:0] rx_word;
   logic [SMP_W-1:0] tx_sh, echo_sh;
   logic [1:0] tx_wcnt;
   logic tx_tick;

   // receive chain
   logic signed [SMP_W-1:0] sel_word;
   logic dup_pend, push, dec_v;
   logic [1:0] dec_cnt;
   logic signed [AW-1:0] dec_sum;
   logic signed [SMP_W-1:0] dec_out;
   logic signed [SMP_W-1:0] teq_dl [TEQ_TAPS];
   logic signed [AW-1:0] teq_acc;

   // transmit chain
   logic signed [SMP_W-1:0] sl_y, de_xp, de_y, ip_prev, ip_cur;
   logic signed [SMP_W-1:0] sl_n, cl_n, de_n, tx_word;
   logic signed [AW-1:0] ip_full;

   // dpll
   logic signed [SMP_W-1:0] lp;
   logic signed [31:0] freq_est, ph_acc, ph_n;
   logic slip_del, slip_ins, set_del, set_ins, use_del, use_ins;
   logic [7:0] del_cnt, ins_cnt;

   // control serial
   dsfe_ser_e ser_state;
   logic [SMP_W-1:0] ser_sh;
   logic [7:0] ser_left;
   logic [7:0] ser_div;

   // ==========================================================
   // apb slave: zero wait states, unmapped access flags an error
   assign o_pready = 1'b1;
   assign wr_en = i_psel && i_penable && i_pwrite && hit;
   assign o_pslverr = i_psel && i_penable && !hit;
   assign teq_idx = i_paddr[7:2] - OFS_TEQ_BASE[7:2];

   // address decode and read mux
   always_comb begin
      hit = 1'b1;
      rd_val = 32'h0000_0000;
      if (i_paddr == OFS_CTRL) begin
         rd_val = {28'h000_0000, ctrl};
      end else if (i_paddr == OFS_CLIP) begin
         rd_val = {17'h0_0000, clip_lvl};
      end else if (i_paddr == OFS_SIDELOBE) begin
         rd_val = {16'h0000, sl_coef};
      end else if (i_paddr == OFS_DELAYEQ) begin
         rd_val = {16'h0000, de_coef};
      end else if (i_paddr == OFS_SLIP_THR) begin
         rd_val = slip_thr;
      end else if (i_paddr == OFS_SER_TX) begin
         rd_val = {16'h0000, ser_sh};
      end else if (i_paddr == OFS_FREQ) begin
         rd_val = freq_est;
      end else if (i_paddr == OFS_STATUS) begin
         rd_val = {8'h00, ins_cnt, del_cnt, 6'h00, ser_state == SER_SHIFT, aligned};
      end else if (teq_hit(i_paddr)) begin
         rd_val = {16'h0000, teq_coef[teq_idx[$clog2(TEQ_TAPS)-1:0]]};
      end else begin
         hit = 1'b0;
      end
   end

   // read data captured in the setup cycle so it is a flop in the access cycle
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         o_prdata <= 32'h0000_0000;
      end else if (i_psel && !i_penable && !i_pwrite) begin
         o_prdata <= rd_val;
      end
   end

   // configuration registers; power off comes out of reset asserted
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         ctrl <= CTRL_RST;
         clip_lvl <= CLIP_RST;
         sl_coef <= COEF_RST;
         de_coef <= COEF_RST;
         slip_thr <= SLIP_THR_RST;
         for (int k = 0; k < TEQ_TAPS; k++) begin
            teq_coef[k] <= (k == 0) ? TEQ_C0_RST : COEF_RST;
         end
      end else if (wr_en) begin
         if (i_paddr == OFS_CTRL) begin
            ctrl <= i_pwdata[3:0];
         end else if (i_paddr == OFS_CLIP) begin
            clip_lvl <= i_pwdata[14:0];
         end else if (i_paddr == OFS_SIDELOBE) begin
            sl_coef <= i_pwdata[15:0];
         end else if (i_paddr == OFS_DELAYEQ) begin
            de_coef <= i_pwdata[15:0];
         end else if (i_paddr == OFS_SLIP_THR) begin
            slip_thr <= i_pwdata;
         end else if (teq_hit(i_paddr)) begin
            teq_coef[teq_idx[$clog2(TEQ_TAPS)-1:0]] <= i_pwdata[15:0];
         end
      end
   end

   assign o_conv_power_off = ctrl.power_off;

   // ==========================================================
   // pin synchronisers; data gets one extra stage to line up with the filtered mark
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         mark_s <= 3'h0;
         rx_s1 <= 4'h0;
         rx_s2 <= 4'h0;
         rx_s3 <= 4'h0;
         rx_d4 <= 4'h0;
      end else begin
         mark_s <= {mark_s[1:0], i_word_start_mark};
         rx_s1 <= i_conv_rx_nibble;
         rx_s2 <= rx_s1;
         rx_s3 <= rx_s2;
         rx_d4 <= rx_s3;
      end
   end

   // mark counts only once stages two and three agree
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         mark_f <= 1'b0;
         mark_f_q <= 1'b0;
      end else begin
         if (mark_s[1] == mark_s[2]) begin
            mark_f <= mark_s[2];
         end
         mark_f_q <= mark_f;
      end
   end

   assign word_start = mark_f && !mark_f_q;
   assign nib_cur = word_start ? FIRST_NIB : nib_idx;
   assign word_done = aligned && (nib_cur == LAST_NIB);
   assign rx_word = {rx_acc, rx_d4};

   // nibble counter: a mark realigns, otherwise it free-runs in fours
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         nib_idx <= FIRST_NIB;
         aligned <= 1'b0;
         rx_acc <= 12'h000;
      end else begin
         nib_idx <= nib_cur + 2'h1;
         if (word_start) begin
            aligned <= 1'b1;
         end
         rx_acc <= {rx_acc[7:0], rx_d4};
      end
   end

   // ==========================================================
   // transmit and echo nibble shifters share one word frame
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         tx_sh <= 16'h0000;
         echo_sh <= 16'h0000;
         o_conv_tx_nibble <= 4'h0;
         o_conv_echo_nibble <= 4'h0;
      end else if (aligned && nib_cur == FIRST_NIB) begin
         tx_sh <= {tx_word[11:0], 4'h0};
         echo_sh <= {i_echo_word[11:0], 4'h0};
         o_conv_tx_nibble <= tx_word[15:12];
         o_conv_echo_nibble <= i_echo_word[15:12];
      end else begin
         tx_sh <= {tx_sh[11:0], 4'h0};
         echo_sh <= {echo_sh[11:0], 4'h0};
         o_conv_tx_nibble <= tx_sh[15:12];
         o_conv_echo_nibble <= echo_sh[15:12];
      end
   end

   // one transmit sample per four link words
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         tx_wcnt <= 2'h0;
      end else if (word_done) begin
         tx_wcnt <= tx_wcnt + 2'h1;
      end
   end

   assign tx_tick = word_done && (tx_wcnt == LAST_WORD);
   assign o_tx_ready = tx_tick;

   // ==========================================================
   // receive chain: selector, decimator, equalizer
   assign sel_word = ctrl.loopback ? tx_word : rx_word;
   assign use_del = word_done && slip_del && !ctrl.loopback;
   assign use_ins = word_done && slip_ins && !ctrl.loopback && !use_del;
   assign push = (word_done && !use_del) || dup_pend;

   // an inserted sample is a second push one cycle later, of the receive word as it stands then
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         dup_pend <= 1'b0;
      end else begin
         dup_pend <= use_ins;
      end
   end

   // decimator: four-sample average, limited but cheap anti-alias
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         dec_cnt <= 2'h0;
         dec_sum <= '0;
         dec_v <= 1'b0;
         dec_out <= 16'h0000;
      end else begin
         dec_v <= 1'b0;
         if (push && ctrl.dec_bypass) begin
            dec_out <= sel_word;
            dec_v <= 1'b1;
         end else if (push) begin
            dec_cnt <= dec_cnt + 2'h1;
            if (dec_cnt == LAST_WORD) begin
               dec_out <= sat16((dec_sum + AW'(sel_word)) >>> DEC_SH);
               dec_v <= 1'b1;
               dec_sum <= '0;
            end else begin
               dec_sum <= dec_sum + AW'(sel_word);
            end
         end
      end
   end

   // equalizer taps: newest sample at tap zero
   always_comb begin
      teq_acc = AW'(teq_coef[0]) * AW'(dec_out);
      for (int k = 1; k < TEQ_TAPS; k++) begin
         teq_acc = teq_acc + AW'(teq_coef[k]) * AW'(teq_dl[k-1]);
      end
   end

   // equalizer delay line and output register
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         for (int k = 0; k < TEQ_TAPS; k++) begin
            teq_dl[k] <= 16'h0000;
         end
         o_rx_sample <= 16'h0000;
         o_rx_valid <= 1'b0;
      end else begin
         o_rx_valid <= dec_v;
         if (dec_v) begin
            teq_dl[0] <= dec_out;
            for (int k = 1; k < TEQ_TAPS; k++) begin
               teq_dl[k] <= teq_dl[k-1];
            end
            o_rx_sample <= ctrl.teq_bypass ? dec_out : sat16(teq_acc >>> Q_SH);
         end
      end
   end

   // ==========================================================
   // transmit chain, evaluated once per transmit sample
   always_comb begin
      sl_n = sat16(AW'(i_tx_sample) + q15mul(sl_coef, sl_y));
      if (sl_n > $signed({1'b0, clip_lvl})) begin
         cl_n = $signed({1'b0, clip_lvl});
      end else if (sl_n < -$signed({1'b0, clip_lvl})) begin
         cl_n = -$signed({1'b0, clip_lvl});
      end else begin
         cl_n = sl_n;
      end
      // first-order all-pass: flat gain, shaped group delay
      de_n = sat16(q15mul(de_coef, cl_n) + AW'(de_xp) - q15mul(de_coef, de_y));
   end

   // linear interpolation, step k of four between the last two samples
   assign ip_full = AW'(ip_prev) + (((AW'(ip_cur) - AW'(ip_prev))
                    * $signed({38'h0, tx_wcnt} + 40'h1)) >>> INTERP_SH);
   assign tx_word = sat16(ip_full);

   // filter states
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         sl_y <= 16'h0000;
         de_xp <= 16'h0000;
         de_y <= 16'h0000;
         ip_prev <= 16'h0000;
         ip_cur <= 16'h0000;
      end else if (tx_tick) begin
         sl_y <= sl_n;
         de_xp <= cl_n;
         de_y <= de_n;
         ip_prev <= ip_cur;
         ip_cur <= de_n;
      end
   end

   // ==========================================================
   // dpll: 32-bit integrator gives sub-ppm offset resolution
   always_comb begin
      ph_n = ph_acc + freq_est;
      set_del = 1'b0;
      set_ins = 1'b0;
      if (ph_n >= slip_thr) begin
         set_del = 1'b1;
         ph_n = ph_n - SLIP_UNIT;
      end else if (ph_n <= -slip_thr) begin
         set_ins = 1'b1;
         ph_n = ph_n + SLIP_UNIT;
      end
   end

   // loop filter, integrator and phase accumulator
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         lp <= 16'h0000;
         freq_est <= 32'h0000_0000;
         ph_acc <= 32'h0000_0000;
         o_rotor_phase <= 16'h0000;
      end else if (i_pilot_valid) begin
         lp <= sat16(AW'(lp) + ((AW'(i_pilot_err) - AW'(lp)) >>> LP_SH));
         freq_est <= freq_est + 32'(lp);
         ph_acc <= ph_n;
         o_rotor_phase <= sat16(AW'(ph_n));
      end
   end

   // slip requests: a new request wins over consumption in the same cycle
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         slip_del <= 1'b0;
         slip_ins <= 1'b0;
         del_cnt <= 8'h00;
         ins_cnt <= 8'h00;
      end else begin
         if (i_pilot_valid && set_del) begin
            slip_del <= 1'b1;
         end else if (use_del) begin
            slip_del <= 1'b0;
            del_cnt <= del_cnt + 8'h01;
         end
         if (i_pilot_valid && set_ins) begin
            slip_ins <= 1'b1;
         end else if (use_ins) begin
            slip_ins <= 1'b0;
            ins_cnt <= ins_cnt + 8'h01;
         end
      end
   end

   // ==========================================================
   // control serial out: msb first, writes while busy are dropped
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         ser_state <= SER_IDLE;
         ser_sh <= 16'h0000;
         ser_left <= 8'h00;
         ser_div <= 8'h00;
         o_conv_ctrl_serial_out <= 1'b0;
      end else begin
         case (ser_state)
            SER_IDLE: begin
               o_conv_ctrl_serial_out <= 1'b0;
               if (wr_en && i_paddr == OFS_SER_TX) begin
                  ser_sh <= i_pwdata[15:0];
                  ser_left <= SER_BITS;
                  ser_div <= 8'h00;
                  ser_state <= SER_SHIFT;
               end
            end
            SER_SHIFT: begin
               if (ser_div == 8'h00) begin
                  if (ser_left == 8'h00) begin
                     ser_state <= SER_IDLE;
                     o_conv_ctrl_serial_out <= 1'b0;
                  end else begin
                     o_conv_ctrl_serial_out <= ser_sh[15];
                     ser_sh <= {ser_sh[14:0], 1'b0};
                     ser_left <= ser_left - 8'h01;
                     ser_div <= 8'(CTRL_BIT_CYC - 1);
                  end
               end else begin
                  ser_div <= ser_div - 8'h01;
               end
            end
            default: begin
               ser_state <= SER_IDLE;
            end
         endcase
      end
   end

endmodule

// file: verilog/dsfe_pkg.sv
// constants, register map and shared types of the sample front end
package dsfe_pkg;
   // ==========================================================
   // link framing
   localparam int SMP_W = 16;
   localparam int NIB_W = 4;
   localparam logic [1:0] FIRST_NIB = 2'h0;
   localparam logic [1:0] LAST_NIB = 2'h3;
   localparam logic [1:0] LAST_WORD = 2'h3;
   // ==========================================================
   // arithmetic
   localparam int AW = 40;
   localparam int Q_SH = 15;
   localparam int DEC_SH = 2;
   localparam int INTERP_SH = 2;
   localparam int LP_SH = 4;
   localparam logic signed [AW-1:0] SAT_HI = 40'sh00_0000_7FFF;
   localparam logic signed [AW-1:0] SAT_LO = 40'shFF_FFFF_8000;
   localparam logic signed [31:0] SLIP_UNIT = 32'sh0001_0000;
   // ==========================================================
   // control serial timing
   localparam int CLK_NS = 40;
   localparam int CTRL_BIT_NS = 400;
   localparam int CTRL_BIT_CYC = (CTRL_BIT_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [7:0] SER_BITS = 8'h10;
   // ==========================================================
   // register offsets (byte addresses)
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CLIP = 8'h04;
   localparam logic [7:0] OFS_SIDELOBE = 8'h08;
   localparam logic [7:0] OFS_DELAYEQ = 8'h0C;
   localparam logic [7:0] OFS_SLIP_THR = 8'h10;
   localparam logic [7:0] OFS_SER_TX = 8'h14;
   localparam logic [7:0] OFS_FREQ = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1C;
   localparam logic [7:0] OFS_TEQ_BASE = 8'h40;
   // ==========================================================
   // reset values
   localparam logic [3:0] CTRL_RST = 4'h1;
   localparam logic [14:0] CLIP_RST = 15'h7FFF;
   localparam logic [15:0] COEF_RST = 16'h0000;
   localparam logic [15:0] TEQ_C0_RST = 16'h7FFF;
   localparam logic [31:0] SLIP_THR_RST = 32'h0000_8000;
   // ==========================================================
   // types
   typedef struct packed {
      logic teq_bypass;
      logic dec_bypass;
      logic loopback;
      logic power_off;
   } dsfe_ctrl_s;
   typedef enum logic [1:0] {
      SER_IDLE = 2'b01,
      SER_SHIFT = 2'b10
   } dsfe_ser_e;
endpackage

// file: test/dsfe_top_asserts.sv
// port checker of the sample front end
`timescale 1ns/1ns
module dsfe_top_asserts
   import dsfe_pkg::*;
(
   input logic i_clk,
   input logic i_rst_b,
   input logic i_psel,
   input logic i_penable,
   input logic i_pwrite,
   input logic [7:0] i_paddr,
   input logic [31:0] i_pwdata,
   input logic [dsfe_pkg::NIB_W-1:0] o_conv_tx_nibble,
   input logic o_conv_power_off,
   input logic o_conv_ctrl_serial_out,
   input logic o_tx_ready,
   input logic o_rx_valid,
   input logic i_pilot_valid,
   input logic signed [dsfe_pkg::SMP_W-1:0] o_rotor_phase
);
   // ====
   // helpers
   logic [7:0] idle_cnt;
   wire ser_wr = i_psel && i_penable && i_pwrite && i_paddr == OFS_SER_TX;
   wire ctrl_wr = i_psel && i_penable && i_pwrite && i_paddr == OFS_CTRL;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   // cycles since a serial start, saturating so a long idle never wraps
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         idle_cnt <= 8'hFF;
      end else if (ser_wr) begin
         idle_cnt <= 8'h00;
      end else if (idle_cnt != 8'hFF) begin
         idle_cnt <= idle_cnt + 8'h01;
      end
   end
   sequence ser_wr_s;
      ser_wr;
   endsequence
   sequence bit_hold_s;
      $stable(o_conv_ctrl_serial_out)[*8];
   endsequence
   // ====
   // properties
   rst_pwr_a: assert property (disable iff (1'b0)
      !i_rst_b |=> o_conv_power_off && o_conv_tx_nibble == 4'h0 && !o_rx_valid)
      else $error("outputs wrong after reset");
   rst_quiet_a: assert property ($rose(i_rst_b) |-> (!o_rx_valid)[*4])
      else $error("receive sample right after reset");
   rx_pulse_a: assert property (o_rx_valid |=> (!o_rx_valid)[*3])
      else $error("receive valid too close");
   tx_rate_a: assert property (o_tx_ready |=>
      (!o_tx_ready)[*8] ##1 (!o_tx_ready)[*7] ##1 o_tx_ready)
      else $error("transmit request not every 16 cycles");
   ser_start_a: assert property (ser_wr_s |=> ##1
      o_conv_ctrl_serial_out == $past(i_pwdata[15], 2) ##1 bit_hold_s)
      else $error("serial first bit wrong");
   ser_idle_a: assert property (idle_cnt > 8'd165 |-> !o_conv_ctrl_serial_out)
      else $error("serial line not idle low");
   rot_hold_a: assert property (!i_pilot_valid |=> $stable(o_rotor_phase))
      else $error("rotor moved without pilot");
   pwr_set_a: assert property (ctrl_wr |=> o_conv_power_off == $past(i_pwdata[0]))
      else $error("power off not following control");
endmodule
bind dsfe_top dsfe_top_asserts u_chk (.i_clk, .i_rst_b, .i_psel, .i_penable, .i_pwrite,
   .i_paddr, .i_pwdata, .o_conv_tx_nibble, .o_conv_power_off, .o_conv_ctrl_serial_out,
   .o_tx_ready, .o_rx_valid, .i_pilot_valid, .o_rotor_phase);

// file: test/dsfe_conv_model.sv
// behavioural converter chip sending receive words over the nibble link
`timescale 1ns/1ns
module dsfe_conv_model (
   input logic i_clk,
   input logic [dsfe_pkg::SMP_W-1:0] i_word,
   output logic [dsfe_pkg::NIB_W-1:0] o_nibble,
   output logic o_mark
);
   logic [1:0] ph = 2'h0;
   logic [15:0] word = 16'h0000;
   initial o_nibble = 4'h0;
   initial o_mark = 1'b0;
   // words run back to back; a word is latched whole so it never tears
   always @(posedge i_clk) begin
      ph <= ph + 2'h1;
      o_mark <= ph[1] == 1'b0;
      if (ph == 2'h0) begin
         word <= i_word;
         o_nibble <= i_word[15:12];
      end else begin
         o_nibble <= word[15 - 4 * ph -: 4];
      end
   end
endmodule

// file: test/test_dmt_sample_front_end.sv
// self-checking bench of the sample front end
`timescale 1ns/1ns
module test_dmt_sample_front_end;
   import dsfe_pkg::*;
   // ====
   // signals
   logic i_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, pval = 1'b0;
   logic pready, pslverr, mark, pwr_off, ser, tx_rdy, rx_v;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata;
   logic [3:0] rx_nib, tx_nib, echo_nib;
   logic [15:0] link_word = 16'h0000, echo_w = 16'h0000;
   logic signed [15:0] tx_smp = 16'sh0000, perr = 16'sh0000, rx_smp, rotor;
   int fails = 0, cmp_count = 0;
   // master clock
   always #20 i_clk = ~i_clk;
   dsfe_top i_dut (.i_clk, .i_rst_b, .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_conv_rx_nibble(rx_nib), .i_word_start_mark(mark),
      .o_conv_tx_nibble(tx_nib), .o_conv_echo_nibble(echo_nib), .o_conv_power_off(pwr_off),
      .o_conv_ctrl_serial_out(ser), .i_tx_sample(tx_smp), .o_tx_ready(tx_rdy),
      .i_echo_word(echo_w), .o_rx_sample(rx_smp), .o_rx_valid(rx_v),
      .i_pilot_err(perr), .i_pilot_valid(pval), .o_rotor_phase(rotor));
   dsfe_conv_model i_conv (.i_clk, .i_word(link_word), .o_nibble(rx_nib), .o_mark(mark));
   // ====
   // shared tasks
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // one transfer; request held until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      int n = 0;
      @(posedge i_clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk);
      pen <= 1'b1;
      do begin
         @(posedge i_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         chk("bus answer", 1, 0);
         give_verdict();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      chk(nm, exp, r);
   endtask
   task automatic wait_rxv(output int n);
      n = 0;
      do begin
         @(negedge i_clk);
         n++;
      end while (rx_v !== 1'b1 && n < 100);
      if (n >= 100) begin
         chk("receive valid", 1, 0);
         give_verdict();
      end
   endtask
   task automatic get_tx(output logic [15:0] t, output logic [15:0] ec);
      int n = 0;
      do begin
         @(negedge i_clk);
         n++;
      end while (echo_nib !== 4'h9 && n < 40);
      if (n >= 40) begin
         chk("echo word start", 1, 0);
         give_verdict();
      end
      for (int i = 0; i < 4; i++) begin
         t = {t[11:0], tx_nib};
         ec = {ec[11:0], echo_nib};
         @(negedge i_clk);
      end
   endtask
   // ====
   // scenarios
   task automatic t_regs;
      logic [31:0] r;
      logic e;
      chk("power off", 1, pwr_off);
      rd_chk("ctrl", OFS_CTRL, 32'h0000_0001);
      rd_chk("tap0", OFS_TEQ_BASE, 32'h0000_7FFF);
      rd_chk("slip thr", OFS_SLIP_THR, 32'h0000_8000);
      apb(1'b0, 8'h30, 32'h0000_0000, r, e);
      chk("unmapped err", 1, e);
      chk("unmapped data", 0, r);
      $display("register test done");
   endtask
   task automatic t_power;
      wr(OFS_CTRL, 32'h0000_0000);
      @(negedge i_clk);
      chk("power off", 0, pwr_off);
      wr(OFS_CTRL, 32'h0000_0001);
      @(negedge i_clk);
      chk("power off", 1, pwr_off);
      $display("power test done");
   endtask
   task automatic t_rx;
      int n;
      logic [15:0] w[2] = '{16'h9A3C, 16'h5BE1};
      wr(OFS_CTRL, 32'h0000_000C);
      foreach (w[i]) begin
         link_word <= w[i];
         repeat (24) @(posedge i_clk);
         wait_rxv(n);
         chk("rx bypass", {16'h0, w[i]}, {16'h0, rx_smp});
      end
      $display("receive bypass test done");
   endtask
   task automatic t_dec;
      int n;
      wr(OFS_CTRL, 32'h0000_0008);
      link_word <= 16'h1234;
      repeat (80) @(posedge i_clk);
      wait_rxv(n);
      wait_rxv(n);
      chk("dec period", 16, n);
      chk("dec sample", 32'h0000_1234, {16'h0, rx_smp});
      $display("decimator test done");
   endtask
   task automatic t_teq;
      int n;
      wr(OFS_TEQ_BASE, 32'h0000_4000);
      wr(OFS_CTRL, 32'h0000_0004);
      repeat (40) @(posedge i_clk);
      wait_rxv(n);
      chk("teq half", 32'h0000_091A, {16'h0, rx_smp});
      $display("equalizer test done");
   endtask
   task automatic t_tx;
      int n;
      logic [15:0] t, ec;
      wr(OFS_CTRL, 32'h0000_000C);
      wr(OFS_CLIP, 32'h0000_1000);
      tx_smp <= 16'sh7000;
      echo_w <= 16'h9124;
      repeat (200) @(posedge i_clk);
      get_tx(t, ec);
      chk("echo word", 32'h0000_9124, {16'h0, ec});
      chk("clip high", 32'h0000_1000, {16'h0, t});
      tx_smp <= 16'sh9000;
      repeat (200) @(posedge i_clk);
      get_tx(t, ec);
      chk("clip low", 32'h0000_F000, {16'h0, t});
      wr(OFS_CTRL, 32'h0000_000E);
      repeat (60) @(posedge i_clk);
      wait_rxv(n);
      chk("loopback", 32'h0000_F000, {16'h0, rx_smp});
      $display("transmit test done");
   endtask
   task automatic t_ser;
      logic [15:0] d = 16'hA5C3;
      wr(OFS_SER_TX, {16'h0, d});
      repeat (2) @(negedge i_clk);
      for (int i = 0; i < 16; i++) begin
         chk("serial bit", {31'h0, d[15 - i]}, {31'h0, ser});
         repeat (10) @(negedge i_clk);
      end
      chk("serial idle", 0, {31'h0, ser});
      $display("serial test done");
   endtask
   task automatic t_dpll;
      int lp = 0, f = 0, ph = 0, del = 0;
      wr(OFS_CTRL, 32'h0000_000C);
      repeat (8) begin
         @(posedge i_clk);
         perr <= 16'sh4000;
         pval <= 1'b1;
         @(posedge i_clk);
         pval <= 1'b0;
         ph += f;
         if (ph >= 32768) begin
            ph -= 65536;
            del++;
         end
         f += lp;
         lp += (16384 - lp) >>> 4;
         repeat (6) @(posedge i_clk);
      end
      @(negedge i_clk);
      chk("rotor", {16'h0, ph[15:0]}, {16'h0, rotor});
      rd_chk("freq", OFS_FREQ, f);
      rd_chk("status", OFS_STATUS, {16'h0, del[7:0], 8'h01});
      $display("dpll test done");
   endtask
   // ====
   // main sequence
   initial begin
      repeat (6) @(posedge i_clk);
      i_rst_b <= 1'b1;
      @(negedge i_clk);
      t_regs();
      t_power();
      t_rx();
      t_dec();
      t_teq();
      t_tx();
      t_ser();
      t_dpll();
      give_verdict();
   end
endmodule
